// [design/pgs_defs.svh]
// Register offsets, field positions, reset values and timing figures of the pump group sequencer
`ifndef PGS_DEFS_SVH
`define PGS_DEFS_SVH

`define PGS_NPUMP 5
`define PGS_CLK_HZ 250_000_000
`define PGS_STEP_S 2
`define PGS_SEC_PER_HOUR 3600

`define PGS_OFS_CTRL 12'h000
`define PGS_OFS_ON_DELAY 12'h004
`define PGS_OFS_OFF_DELAY 12'h008
`define PGS_OFS_BAND 12'h00C
`define PGS_OFS_SW_SPEED 12'h010
`define PGS_OFS_ROT_THR 12'h014
`define PGS_OFS_HOUR_LIM 12'h018
`define PGS_OFS_LEADER 12'h01C
`define PGS_OFS_HOURS 12'h020
`define PGS_OFS_STATUS 12'h024
`define PGS_OFS_PT_PTR 12'h028
`define PGS_OFS_PT_DATA 12'h02C

`define PGS_CTRL_EN 0
`define PGS_CTRL_LIM_LSB 1
`define PGS_CTRL_MODE_LSB 4

`define PGS_RST_LIMIT 3'h5
`define PGS_RST_MODE 5'h1F
`define PGS_RST_DELAY 32'h0000_0100
`define PGS_PID_FULL 16'hFFFF
`define PGS_PID_ZERO 16'h0000

`define PGS_NPTS 512
`define PGS_PT_DIG 9'h000
`define PGS_PT_ANA 9'h080
`define PGS_PT_LOGIC 9'h100
`define PGS_PT_SERIAL 9'h180
`define PGS_PT_EXP 9'h1C0

`endif

// [design/pgs_pkg.sv]
// Types shared by the pump group sequencer
`include "pgs_defs.svh"
package pgs_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pgs_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pgs_apb_rsp_s;

   typedef enum logic [2:0] {PGS_NORMAL, PGS_SLOW, PGS_ROT_ADD, PGS_ROT_LEAD, PGS_ROT_NEW}
      pgs_state_e;

   typedef logic [2:0] pgs_idx_t;

   typedef struct packed {
      pgs_state_e st;
      logic [2:0] en_s1, en_s2, en_s3;
      logic [4:0] en_s1w, en_s2w, en_s3w;
      logic [4:0] pump_en;
      logic [4:0] pumps;
      pgs_idx_t lead;
      pgs_idx_t new_lead;
      logic speed_drop;
      logic ctl_en;
      logic [2:0] limit;
      logic [4:0] mode;
      logic [31:0] on_delay, off_delay, on_cnt, off_cnt;
      logic [15:0] band, sw_speed, rot_thr, hour_lim, hours;
      logic [31:0] sec_cnt, step_cnt;
      logic [11:0] sec_in_hour;
      logic [8:0] ptr;
      logic [`PGS_NPTS-1:0][15:0] pts;
      logic [15:0] ptr_val;
      logic ptr_logic;
      pgs_apb_rsp_s rsp;
   } pgs_regs_s;
endpackage

// [design/pgs_sequencer.sv]
// Pump group sequencer with characteristic point table and APB register slave
//
// Contract
// - Switch-on request needs PID at full scale and pressure below reference by band, held.
// - On request, slow the leading pump to switch-over speed, then energise extra pump.
// - Drop latest added pump when PID is zero and pressure above band, held.
// - Inside reference plus or minus band, the set of running pumps stays.
// - Switch-on scans upward cyclically from leader plus one, first free unblocked pump.
// - Switch-off scans downward cyclically from leader minus one, first running pump.
// - A blocked additional pump stops at once; later starts take first ready pump.
// - A blocked leading pump stops every pump at once.
// - No start while running count including leader equals the pump limit.
// - Rotation needs hour limit, low reference, another leader candidate, limit of two.
// - Rotation first stops additional pumps one per two-second step, switch-off order.
// - Then leader off within one step, new leader on after another step.
// - New leader is next in switch-on order, unblocked and drive capable.
// - After rotation hours restart for the new leader and normal switching resumes.
// - Leader identity and hours are kept across power loss and reused; here reset clears both and software writes them back.
// - After a blocked leader stops all, next eligible pump becomes the leader.
// - Table of 512 characteristic points, 16 bits each, signed or unsigned.
// - A point used as logic is low when zero, high otherwise.
// - Point ranges: digital, analog, logic unit, serial writable, expansion, ascending.
// - Pointer 0 to 511 selects a point and outputs its current content.
// - A blocked pump is never switched on, as leader or additional.
// - A grid-only pump never leads, it only runs as additional pump.
// - At most five pumps, one contactor output each.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "pgs_defs.svh"

module pgs_sequencer
   import pgs_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = `PGS_CLK_HZ
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire pgs_pkg::pgs_apb_req_s apb_req,
   output var pgs_pkg::pgs_apb_rsp_s apb_rsp,
   input wire logic [15:0] pid_out,
   input wire logic [15:0] pressure,
   input wire logic [15:0] pressure_ref,
   input wire logic [15:0] leader_speed,
   input wire logic [4:0] pump_enable_pins,
   output logic [4:0] pump_contactor,
   output logic speed_drop_req,
   output logic [15:0] switch_over_speed,
   output logic [2:0] leader_index,
   output logic [15:0] point_value,
   output logic point_logic
);
   import pgs_pkg::*;

   localparam logic [31:0] STEP_CYCLES = 32'(`PGS_STEP_S * SEC_CYCLES);
   localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);

   pgs_regs_s r_r;
   pgs_regs_s r_nxt;

   function automatic pgs_idx_t idx_up(input pgs_idx_t i);
      idx_up = (i == pgs_idx_t'(`PGS_NPUMP - 1)) ? pgs_idx_t'(0) : pgs_idx_t'(i + 3'd1);
   endfunction

   function automatic pgs_idx_t idx_dn(input pgs_idx_t i);
      idx_dn = (i == pgs_idx_t'(0)) ? pgs_idx_t'(`PGS_NPUMP - 1) : pgs_idx_t'(i - 3'd1);
   endfunction

   // Upward cyclic scan from the pump after the leader; found flag in bit 3
   function automatic logic [3:0] scan_up(input pgs_idx_t lead, input logic [4:0] ok);
      pgs_idx_t i;
      logic [3:0] res;
      i = lead;
      res = 4'h0;
      for (int k = 0; k < `PGS_NPUMP - 1; k++) begin
         i = idx_up(i);
         if (!res[3] && ok[i]) begin
            res = {1'b1, i};
         end
      end
      scan_up = res;
   endfunction

   // Downward cyclic scan from the pump before the leader
   function automatic logic [3:0] scan_dn(input pgs_idx_t lead, input logic [4:0] ok);
      pgs_idx_t i;
      logic [3:0] res;
      i = lead;
      res = 4'h0;
      for (int k = 0; k < `PGS_NPUMP - 1; k++) begin
         i = idx_dn(i);
         if (!res[3] && ok[i]) begin
            res = {1'b1, i};
         end
      end
      scan_dn = res;
   endfunction

   function automatic logic [2:0] count5(input logic [4:0] v);
      logic [2:0] c;
      c = 3'd0;
      for (int k = 0; k < `PGS_NPUMP; k++) begin
         c = c + {2'b00, v[k]};
      end
      count5 = c;
   endfunction

   logic [16:0] pres_band;
   logic [16:0] ref_band;
   logic cond_on;
   logic cond_off;
   logic on_ok;
   logic off_ok;

   logic [4:0] extra;
   logic [4:0] lead_ok;
   logic [3:0] on_pick;
   logic [3:0] off_pick;
   logic [3:0] lead_pick;

   logic can_start;
   logic step_tick;

   logic acc;
   logic wr;
   logic rd;
   logic hit;
   logic [31:0] rdata;
   logic pt_wr_ok;

   always_comb begin
      pres_band = {1'b0, pressure} + {1'b0, r_r.band};
      ref_band = {1'b0, pressure_ref} + {1'b0, r_r.band};
      cond_on = (pid_out == `PGS_PID_FULL) && ({1'b0, pressure_ref} >= pres_band);
      cond_off = (pid_out == `PGS_PID_ZERO) && ({1'b0, pressure} >= ref_band);
      on_ok = cond_on && (r_r.on_cnt >= r_r.on_delay);
      off_ok = cond_off && (r_r.off_cnt >= r_r.off_delay);
      extra = r_r.pumps & ~(5'b00001 << r_r.lead);
      lead_ok = r_r.pump_en & r_r.mode;
      on_pick = scan_up(r_r.lead, r_r.pump_en & ~r_r.pumps);
      off_pick = scan_dn(r_r.lead, extra);
      lead_pick = scan_up(r_r.lead, lead_ok);
      can_start = on_pick[3] && (count5(r_r.pumps) < r_r.limit);
      step_tick = (r_r.step_cnt >= STEP_CYCLES - 32'd1);

      acc = apb_req.psel && apb_req.penable && r_r.rsp.pready;
      wr = acc && apb_req.pwrite;
      rd = apb_req.psel && apb_req.penable && !r_r.rsp.pready && !apb_req.pwrite;
      pt_wr_ok = (r_r.ptr >= `PGS_PT_SERIAL);

      hit = 1'b1;
      rdata = 32'h0000_0000;
      case (apb_req.paddr)
         `PGS_OFS_CTRL: rdata = {23'h00_0000, r_r.mode, r_r.limit, r_r.ctl_en};
         `PGS_OFS_ON_DELAY: rdata = r_r.on_delay;
         `PGS_OFS_OFF_DELAY: rdata = r_r.off_delay;
         `PGS_OFS_BAND: rdata = {16'h0000, r_r.band};
         `PGS_OFS_SW_SPEED: rdata = {16'h0000, r_r.sw_speed};
         `PGS_OFS_ROT_THR: rdata = {16'h0000, r_r.rot_thr};
         `PGS_OFS_HOUR_LIM: rdata = {16'h0000, r_r.hour_lim};
         `PGS_OFS_LEADER: rdata = {29'h0000_0000, r_r.lead};
         `PGS_OFS_HOURS: rdata = {16'h0000, r_r.hours};
         `PGS_OFS_STATUS: rdata = {18'h0_0000, r_r.st, r_r.speed_drop, r_r.pump_en, r_r.pumps};
         `PGS_OFS_PT_PTR: rdata = {23'h00_0000, r_r.ptr};
         `PGS_OFS_PT_DATA: rdata = {16'h0000, r_r.pts[r_r.ptr]};
         default: hit = 1'b0;
      endcase
   end

   always_comb begin
      r_nxt = r_r;

      // Pin synchroniser: a change counts once stages two and three agree
      r_nxt.en_s1w = pump_enable_pins;
      r_nxt.en_s2w = r_r.en_s1w;
      r_nxt.en_s3w = r_r.en_s2w;
      for (int k = 0; k < `PGS_NPUMP; k++) begin
         if (r_r.en_s2w[k] == r_r.en_s3w[k]) begin
            r_nxt.pump_en[k] = r_r.en_s2w[k];
         end
      end

      // APB slave: ready one cycle into the access phase, write at the edge that completes the access
      r_nxt.rsp.pready = apb_req.psel && apb_req.penable && !r_r.rsp.pready;
      r_nxt.rsp.pslverr = 1'b0;
      if (rd || (apb_req.psel && apb_req.penable && !r_r.rsp.pready)) begin
         r_nxt.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rdata;
         r_nxt.rsp.pslverr = !hit || (apb_req.pwrite && (apb_req.paddr == `PGS_OFS_STATUS))
            || (apb_req.pwrite && (apb_req.paddr == `PGS_OFS_PT_DATA) && !pt_wr_ok);
      end

      if (wr) begin
         case (apb_req.paddr)
            `PGS_OFS_CTRL: begin
               r_nxt.ctl_en = apb_req.pwdata[`PGS_CTRL_EN];
               r_nxt.limit = apb_req.pwdata[`PGS_CTRL_LIM_LSB +: 3];
               r_nxt.mode = apb_req.pwdata[`PGS_CTRL_MODE_LSB +: 5];
            end
            `PGS_OFS_ON_DELAY: r_nxt.on_delay = apb_req.pwdata;
            `PGS_OFS_OFF_DELAY: r_nxt.off_delay = apb_req.pwdata;
            `PGS_OFS_BAND: r_nxt.band = apb_req.pwdata[15:0];
            `PGS_OFS_SW_SPEED: r_nxt.sw_speed = apb_req.pwdata[15:0];
            `PGS_OFS_ROT_THR: r_nxt.rot_thr = apb_req.pwdata[15:0];
            `PGS_OFS_HOUR_LIM: r_nxt.hour_lim = apb_req.pwdata[15:0];
            `PGS_OFS_LEADER: begin
               if (apb_req.pwdata[2:0] < 3'(`PGS_NPUMP)) begin
                  r_nxt.lead = apb_req.pwdata[2:0];
               end
            end
            `PGS_OFS_HOURS: r_nxt.hours = apb_req.pwdata[15:0];
            `PGS_OFS_PT_PTR: r_nxt.ptr = apb_req.pwdata[8:0];
            `PGS_OFS_PT_DATA: begin
               if (pt_wr_ok) begin
                  r_nxt.pts[r_r.ptr] = apb_req.pwdata[15:0];
               end
            end
            default: ;
         endcase
      end

      // Hold-time qualifiers restart whenever their condition fails
      r_nxt.on_cnt = (cond_on && r_r.on_cnt != 32'hFFFF_FFFF) ? r_r.on_cnt + 32'd1
                                                               : (cond_on ? r_r.on_cnt : 32'd0);
      r_nxt.off_cnt = (cond_off && r_r.off_cnt != 32'hFFFF_FFFF) ? r_r.off_cnt + 32'd1
                                                                 : (cond_off ? r_r.off_cnt : 32'd0);

      // Operating hours of the leading pump
      if (r_r.pumps[r_r.lead]) begin
         if (r_r.sec_cnt >= SEC_LAST) begin
            r_nxt.sec_cnt = 32'd0;
            if (r_r.sec_in_hour == 12'(`PGS_SEC_PER_HOUR - 1)) begin
               r_nxt.sec_in_hour = 12'd0;
               if (r_r.hours != 16'hFFFF) begin
                  r_nxt.hours = r_r.hours + 16'd1;
               end
            end else begin
               r_nxt.sec_in_hour = r_r.sec_in_hour + 12'd1;
            end
         end else begin
            r_nxt.sec_cnt = r_r.sec_cnt + 32'd1;
         end
      end

      r_nxt.step_cnt = step_tick ? 32'd0 : r_r.step_cnt + 32'd1;

      // A blocked additional pump drops at once
      r_nxt.pumps = r_r.pumps & (r_r.pump_en | (5'b00001 << r_r.lead));

      if (!r_r.ctl_en) begin
         r_nxt.st = PGS_NORMAL;
         r_nxt.pumps = 5'b00000;
         r_nxt.speed_drop = 1'b0;
      end else if (!lead_ok[r_r.lead]) begin
         // Leader blocked or not drive capable: everything off, pick the next leader
         r_nxt.st = PGS_NORMAL;
         r_nxt.pumps = 5'b00000;
         r_nxt.speed_drop = 1'b0;
         if (lead_pick[3]) begin
            r_nxt.lead = lead_pick[2:0];
            r_nxt.hours = 16'd0;
            r_nxt.sec_in_hour = 12'd0;
            r_nxt.sec_cnt = 32'd0;
         end
      end else begin
         case (r_r.st)
            PGS_NORMAL: begin
               r_nxt.speed_drop = 1'b0;
               if (!r_r.pumps[r_r.lead]) begin
                  r_nxt.pumps[r_r.lead] = 1'b1;
               end else if ((r_r.hours >= r_r.hour_lim) && (pressure_ref <= r_r.rot_thr)
                            && lead_pick[3] && (r_r.limit >= 3'd2)) begin
                  r_nxt.st = PGS_ROT_ADD;
                  r_nxt.step_cnt = 32'd0;
               end else if (on_ok && can_start) begin
                  r_nxt.st = PGS_SLOW;
                  r_nxt.speed_drop = 1'b1;
               end else if (off_ok && off_pick[3]) begin
                  r_nxt.pumps[off_pick[2:0]] = 1'b0;
                  r_nxt.off_cnt = 32'd0;
               end
               // Within the band neither qualifier holds, so the set is kept
            end
            PGS_SLOW: begin
               if (!on_ok || !can_start) begin
                  r_nxt.st = PGS_NORMAL;
                  r_nxt.speed_drop = 1'b0;
               end else if (leader_speed <= r_r.sw_speed) begin
                  r_nxt.pumps[on_pick[2:0]] = 1'b1;
                  r_nxt.st = PGS_NORMAL;
                  r_nxt.speed_drop = 1'b0;
                  r_nxt.on_cnt = 32'd0;
               end
            end
            PGS_ROT_ADD: begin
               if (step_tick) begin
                  if (off_pick[3]) begin
                     r_nxt.pumps[off_pick[2:0]] = 1'b0;
                  end else begin
                     r_nxt.pumps[r_r.lead] = 1'b0;
                     r_nxt.new_lead = lead_pick[2:0];
                     r_nxt.st = PGS_ROT_LEAD;
                  end
               end
            end
            PGS_ROT_LEAD: begin
               r_nxt.pumps[r_r.lead] = 1'b0;
               if (step_tick) begin
                  if (lead_ok[r_r.new_lead]) begin
                     r_nxt.lead = r_r.new_lead;
                     r_nxt.pumps = 5'b00001 << r_r.new_lead;
                     r_nxt.hours = 16'd0;
                     r_nxt.sec_in_hour = 12'd0;
                     r_nxt.sec_cnt = 32'd0;
                  end
                  r_nxt.st = PGS_NORMAL;
                  r_nxt.on_cnt = 32'd0;
                  r_nxt.off_cnt = 32'd0;
               end
            end
            default: r_nxt.st = PGS_NORMAL;
         endcase

         if (r_r.st inside {PGS_ROT_ADD, PGS_ROT_LEAD}) begin
            r_nxt.on_cnt = 32'd0;
            r_nxt.off_cnt = 32'd0;
         end
      end

      // Live points: pump states, enables, analog values and internal status
      for (int k = 0; k < `PGS_NPUMP; k++) begin
         r_nxt.pts[`PGS_PT_DIG + 9'(k)] = {15'h0000, r_r.pumps[k]};
         r_nxt.pts[`PGS_PT_DIG + 9'(k + `PGS_NPUMP)] = {15'h0000, r_r.pump_en[k]};
      end

      r_nxt.pts[`PGS_PT_ANA] = pressure;
      r_nxt.pts[`PGS_PT_ANA + 9'd1] = pressure_ref;
      r_nxt.pts[`PGS_PT_ANA + 9'd2] = pid_out;
      r_nxt.pts[`PGS_PT_ANA + 9'd3] = leader_speed;
      r_nxt.pts[`PGS_PT_LOGIC] = {13'h0000, r_r.lead};
      r_nxt.pts[`PGS_PT_LOGIC + 9'd1] = r_r.hours;

      r_nxt.ptr_val = r_r.pts[r_r.ptr];
      r_nxt.ptr_logic = (r_r.pts[r_r.ptr] != 16'h0000);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_r <= '0;
         r_r.limit <= `PGS_RST_LIMIT;
         r_r.mode <= `PGS_RST_MODE;
         r_r.on_delay <= `PGS_RST_DELAY;
         r_r.off_delay <= `PGS_RST_DELAY;
         r_r.st <= PGS_NORMAL;
         r_r.en_s1w <= 5'h1F;
         r_r.en_s2w <= 5'h1F;
         r_r.en_s3w <= 5'h1F;
         r_r.pump_en <= 5'h1F;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign apb_rsp = r_r.rsp;
   assign pump_contactor = r_r.pumps;
   assign speed_drop_req = r_r.speed_drop;
   assign switch_over_speed = r_r.sw_speed;
   assign leader_index = r_r.lead;
   assign point_value = r_r.ptr_val;
   assign point_logic = r_r.ptr_logic;
endmodule // pgs_sequencer
`default_nettype wire

// [test/pgs_sequencer_monitor.sv]
// Port-level assertions for the pump group sequencer
`timescale 1ns/1ns
`default_nettype none
module pgs_sequencer_monitor
   import pgs_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire pgs_pkg::pgs_apb_req_s apb_req,
   input wire pgs_pkg::pgs_apb_rsp_s apb_rsp,
   input wire logic [15:0] pid_out,
   input wire logic [15:0] pressure,
   input wire logic [15:0] pressure_ref,
   input wire logic [15:0] leader_speed,
   input wire logic [4:0] pump_enable_pins,
   input wire logic [4:0] pump_contactor,
   input wire logic speed_drop_req,
   input wire logic [15:0] switch_over_speed,
   input wire logic [2:0] leader_index,
   input wire logic [15:0] point_value,
   input wire logic point_logic
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   logic wr_done;
   assign acc = apb_req.psel && apb_req.penable;
   assign wr_done = apb_rsp.pready && apb_req.pwrite;
   apb_wait_a: assert property (acc && !apb_rsp.pready |=> apb_rsp.pready)
      else $error("pready late");
   ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready longer than one cycle");
   unmapped_err_a: assert property (apb_rsp.pready && apb_req.paddr > 12'h02C
      |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   status_ro_a: assert property (wr_done && apb_req.paddr == 12'h024 |-> apb_rsp.pslverr)
      else $error("status write not refused");
   sw_speed_a: assert property (wr_done && apb_req.paddr == 12'h010
      |-> ##2 switch_over_speed == $past(apb_req.pwdata[15:0], 2))
      else $error("switch-over speed not updated");
   lead_keep_a: assert property (wr_done && apb_req.paddr == 12'h01C
      && apb_req.pwdata > 32'h0000_0004 |=> $stable(leader_index))
      else $error("bad leader index accepted");
   drop_cause_a: assert property ($rose(speed_drop_req) |->
      $past(pid_out) == 16'hFFFF && $past(pressure) < $past(pressure_ref))
      else $error("speed drop without start condition");
   slow_first_a: assert property ($past(pump_contactor) != 5'h00 &&
      (pump_contactor & ~$past(pump_contactor)) != 5'h00
      |-> $past(speed_drop_req) && leader_speed <= switch_over_speed)
      else $error("pump added before leader slowed");
   never_blocked_a: assert property ((pump_contactor & ~$past(pump_contactor)
      & ~$past(pump_enable_pins, 5)) == 5'h00)
      else $error("blocked pump switched on");
   blocked_off_a: assert property (((pump_contactor & ~pump_enable_pins) != 5'h00) [*7]
      |-> 1'b0)
      else $error("blocked pump kept running");
   point_logic_a: assert property (point_logic == (point_value != 16'h0000))
      else $error("point logic level wrong");
   cover property ($rose(speed_drop_req));
   cover property ($changed(leader_index));
   cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule // pgs_sequencer_monitor
`default_nettype wire

// [test/pgs_pump_model.sv]
// Pump side model: enable pins from a block mask and a leader that slows on request
`timescale 1ns/1ns
`default_nettype none
module pgs_pump_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [4:0] pump_contactor,
   input wire logic speed_drop_req,
   input wire logic [15:0] switch_over_speed,
   input wire logic [4:0] block_mask,
   input wire logic slow,
   output logic [4:0] pump_enable_pins,
   output logic [15:0] leader_speed
);
   logic [15:0] step;
   assign step = slow ? 16'h0400 : 16'h2000;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pump_enable_pins <= 5'h1F;
         leader_speed <= 16'h0000;
      end else begin
         pump_enable_pins <= ~block_mask;
         if (pump_contactor == 5'h00) begin
            leader_speed <= 16'h0000;
         end else if (!speed_drop_req) begin
            leader_speed <= 16'h8000;
         end else if (leader_speed > switch_over_speed + step) begin
            leader_speed <= leader_speed - step;
         end else begin
            leader_speed <= switch_over_speed;
         end
      end
   end
endmodule // pgs_pump_model
`default_nettype wire

// [test/pgs_sequencer_test.sv]
// Self-checking bench for the pump group sequencer
`timescale 1ns/1ns
`default_nettype none
module pgs_sequencer_test;
   import pgs_pkg::*;
   localparam int SEC = 10;
   localparam int STEP = 2 * SEC;
   typedef struct packed {logic w; logic [11:0] a; logic [31:0] v; logic e;} pgs_row_s;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   pgs_apb_req_s req = '0;
   pgs_apb_rsp_s rsp;
   logic [15:0] pid = 16'h8000;
   logic [15:0] prs = 16'h0800;
   logic [15:0] pref = 16'h0800;
   logic [15:0] spd, sws, pval;
   logic [4:0] pins, pc;
   logic [4:0] blk = 5'h00;
   logic slow = 1'b1;
   logic sdr, plog, rerr;
   logic [2:0] lead;
   logic [31:0] rdat;
   int num_errors = 0;
   int n_checks = 0;
   pgs_row_s rows [18] = '{
      '{1'b0, 12'h000, 32'h0000_01FA, 1'b0}, '{1'b0, 12'h004, 32'h0000_0100, 1'b0},
      '{1'b0, 12'h008, 32'h0000_0100, 1'b0}, '{1'b0, 12'h01C, 32'h0000_0000, 1'b0},
      '{1'b1, 12'h030, 32'h0000_1234, 1'b1}, '{1'b0, 12'h030, 32'h0000_0000, 1'b1},
      '{1'b1, 12'h024, 32'h0000_0001, 1'b1}, '{1'b1, 12'h028, 32'h0000_0005, 1'b0},
      '{1'b1, 12'h02C, 32'h0000_0055, 1'b1}, '{1'b1, 12'h010, 32'h0000_4000, 1'b0},
      '{1'b0, 12'h010, 32'h0000_4000, 1'b0}, '{1'b1, 12'h00C, 32'h0000_0010, 1'b0},
      '{1'b1, 12'h004, 32'h0000_0004, 1'b0}, '{1'b1, 12'h008, 32'h0000_0004, 1'b0},
      '{1'b1, 12'h01C, 32'h0000_0007, 1'b0}, '{1'b0, 12'h01C, 32'h0000_0000, 1'b0},
      '{1'b1, 12'h028, 32'h0000_0190, 1'b0}, '{1'b1, 12'h02C, 32'h0000_8001, 1'b0}};
   always #2 pclk = ~pclk;
   pgs_sequencer #(.SEC_CYCLES(SEC)) pgs_sequencer_inst (.pclk(pclk), .presetn(presetn),
      .apb_req(req), .apb_rsp(rsp), .pid_out(pid), .pressure(prs), .pressure_ref(pref),
      .leader_speed(spd), .pump_enable_pins(pins), .pump_contactor(pc), .speed_drop_req(sdr),
      .switch_over_speed(sws), .leader_index(lead), .point_value(pval), .point_logic(plog));
   pgs_pump_model pgs_pump_model_inst (.pclk(pclk), .presetn(presetn), .pump_contactor(pc),
      .speed_drop_req(sdr), .switch_over_speed(sws), .block_mask(blk), .slow(slow),
      .pump_enable_pins(pins), .leader_speed(spd));
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      if (rsp.pready !== 1'b1) begin
         num_errors++;
         end_sim();
      end
      rdat = rsp.prdata;
      rerr = rsp.pslverr;
      req <= '0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] q);
      xfer(1'b0, a, 32'h0000_0000);
      cmp(rdat, q);
   endtask
   task automatic wt(input logic [4:0] e, input int lim);
      int n = 0;
      while (pc !== e && n < lim) begin
         @(posedge pclk);
         n++;
      end
      cmp(32'(pc), 32'(e));
      if (pc !== e) end_sim();
   endtask
   task automatic hold(input logic [4:0] e, input int lim);
      repeat (lim) begin
         @(posedge pclk);
         cmp(32'(pc), 32'(e));
      end
   endtask
   task automatic drive(input logic [15:0] p, input logic [15:0] q, input logic [4:0] b);
      @(posedge pclk);
      pid <= p;
      prs <= q;
      blk <= b;
   endtask
   initial begin
      repeat (100000) @(posedge pclk);
      num_errors++;
      end_sim();
   end
   initial begin
      repeat (12) @(posedge pclk);
      cmp(32'(pc), 32'h0000_0000);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         xfer(rows[i].w, rows[i].a, rows[i].v);
         if (!rows[i].w) cmp(rdat, rows[i].v);
         cmp(32'(rerr), 32'(rows[i].e));
      end
      repeat (3) @(posedge pclk);
      cmp(32'(pval), 32'h0000_8001);
      cmp(32'(plog), 32'h0000_0001);
      xfer(1'b1, 12'h02C, 32'h0000_0000);
      repeat (3) @(posedge pclk);
      cmp(32'(plog), 32'h0000_0000);
      xfer(1'b1, 12'h028, 32'h0000_0080);
      repeat (3) @(posedge pclk);
      cmp(32'(pval), 32'h0000_0800);
      xfer(1'b1, 12'h028, 32'h0000_01FF);
      xfer(1'b1, 12'h02C, 32'h0000_FFFF);
      rd(12'h02C, 32'h0000_FFFF);
      // Leader 0 comes up, then additional pumps join
      xfer(1'b1, 12'h000, 32'h0000_01FB);
      wt(5'h01, 40);
      drive(16'hFFFF, 16'h07F8, 5'h00);
      hold(5'h01, 20);
      drive(16'hFFFF, 16'h07F0, 5'h00);
      hold(5'h01, 12);
      wt(5'h03, 60);
      slow <= 1'b0;
      drive(16'h0000, 16'h0808, 5'h00);
      hold(5'h03, 20);
      drive(16'hFFFF, 16'h07F0, 5'h04);
      wt(5'h0B, 60);
      wt(5'h1B, 60);
      xfer(1'b1, 12'h000, 32'h0000_01F9);
      drive(16'hFFFF, 16'h07F0, 5'h00);
      hold(5'h1B, 30);
      xfer(1'b1, 12'h000, 32'h0000_01FB);
      wt(5'h1F, 40);
      drive(16'h0000, 16'h0810, 5'h00);
      wt(5'h0F, 40);
      wt(5'h07, 40);
      drive(16'h8000, 16'h0800, 5'h02);
      wt(5'h05, 12);
      drive(16'h8000, 16'h0800, 5'h00);
      hold(5'h05, 8);
      drive(16'hFFFF, 16'h07F0, 5'h00);
      wt(5'h07, 40);
      drive(16'h8000, 16'h0800, 5'h01);
      wt(5'h00, 12);
      wt(5'h02, 20);
      cmp(32'(lead), 32'h0000_0001);
      drive(16'hFFFF, 16'h07F0, 5'h00);
      wt(5'h06, 40);
      // Rotation: blocked by threshold first, then timed steps
      drive(16'h8000, 16'h0800, 5'h00);
      xfer(1'b1, 12'h014, 32'h0000_0100);
      xfer(1'b1, 12'h018, 32'h0000_0001);
      xfer(1'b1, 12'h020, 32'h0000_0001);
      hold(5'h06, 50);
      xfer(1'b1, 12'h014, 32'h0000_0800);
      wt(5'h02, STEP + 4);
      hold(5'h02, STEP - 3);
      wt(5'h00, 6);
      hold(5'h00, STEP - 3);
      wt(5'h04, 6);
      cmp(32'(lead), 32'h0000_0002);
      rd(12'h020, 32'h0000_0000);
      drive(16'hFFFF, 16'h07F0, 5'h00);
      wt(5'h0C, 40);
      // Leader and hours restored by register writes while control is disabled
      drive(16'h8000, 16'h0800, 5'h00);
      xfer(1'b1, 12'h000, 32'h0000_01FA);
      wt(5'h00, 10);
      xfer(1'b1, 12'h018, 32'h0000_0064);
      xfer(1'b1, 12'h01C, 32'h0000_0003);
      xfer(1'b1, 12'h020, 32'h0000_0005);
      rd(12'h01C, 32'h0000_0003);
      rd(12'h020, 32'h0000_0005);
      xfer(1'b1, 12'h000, 32'h0000_01FB);
      wt(5'h08, 20);
      cmp(32'(lead), 32'h0000_0003);
      // Pump 4 is grid only, so leadership skips it
      xfer(1'b1, 12'h000, 32'h0000_00FB);
      drive(16'h8000, 16'h0800, 5'h08);
      wt(5'h00, 12);
      wt(5'h01, 20);
      cmp(32'(lead), 32'h0000_0000);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      cmp(32'(pc), 32'h0000_0000);
      presetn <= 1'b1;
      rd(12'h000, 32'h0000_01FA);
      end_sim();
   end
endmodule // pgs_sequencer_test
bind pgs_sequencer pgs_sequencer_monitor #(.SEC_CYCLES(SEC_CYCLES)) pgs_sequencer_monitor_inst (
   .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .pid_out(pid_out),
   .pressure(pressure), .pressure_ref(pressure_ref), .leader_speed(leader_speed),
   .pump_enable_pins(pump_enable_pins), .pump_contactor(pump_contactor),
   .speed_drop_req(speed_drop_req), .switch_over_speed(switch_over_speed),
   .leader_index(leader_index), .point_value(point_value), .point_logic(point_logic));
`default_nettype wire
